// ### alias_mailbox_pkg.sv
package alias_mailbox_pkg;
  localparam logic [7:0] ADDR_ALIAS = 8'h17;
  localparam logic [7:0] ADDR_MBOX_A = 8'h18;
  localparam logic [7:0] ADDR_MBOX_B = 8'h19;
  localparam logic [7:0] ADDR_PINCFG = 8'h1a;
  localparam logic [7:0] RST_ALIAS = 8'h00;
  localparam logic [7:0] RST_MBOX_A = 8'h00;
  localparam logic [7:0] RST_MBOX_B = 8'h01;
  localparam logic [7:0] RST_PINCFG = 8'h00;
  localparam int GLB_LEVEL_BIT = 7;
  localparam int GLB_DIR_BIT = 5;
  localparam int GLB_EN_BIT = 4;
  localparam int P9_LEVEL_BIT = 3;
  localparam int P9_DIR_BIT = 1;
  localparam int P9_SEL_BIT = 0;
  localparam int NUM_PINS = 4;

  typedef enum logic [1:0] {
    PIN_FUNC_OUT,
    PIN_HIZ,
    PIN_GP_OUT,
    PIN_GP_IN
  } pin_mode_e;

  typedef struct packed {
    logic valid;
    logic [6:0] addr;
    logic rnw;
  } txn_s;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;
endpackage : alias_mailbox_pkg

// ### alias_mailbox_pin_config_regs.sv
// What this block does
// - The alias register holds a 7-bit address in bits 7..1 compared against local transactions.
// - A matching transaction is forwarded with its address replaced by the remote target ID.
// - An alias value of zero disables matching and forwarding for the slot.
// - The alias register at 0x17 resets to zero.
// - Both mailboxes are plain 8-bit read/write stores, reached only through the local register port.
// - The first mailbox at 0x18 resets to zero.
// - The second mailbox at 0x19 resets to one.
// - The global level bit 7 drives every pin not individually enabled, except pin 9, when global mode is output.
// - Global {direction, enable} decode: 00 functional, 10 tri-state, 01 forced out, 11 forced in.
// - Per-pin settings take priority over the global force settings.
// - Pin 9 level bit 3 drives the pin only when selected, output and not remotely controlled.
// - Pin 9 {direction, select} decode: 00 functional, 10 tri-state, 01 GP out, 11 GP in.
// - The pin configuration register at 0x1a resets to zero.
`timescale 1ns/10ps
`default_nettype none
module alias_mailbox_pin_config_regs (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  input wire alias_mailbox_pkg::reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  input wire alias_mailbox_pkg::txn_s local_txn,
  input wire logic [6:0] remote_target_id,
  output alias_mailbox_pkg::txn_s fwd_txn,
  input wire logic pin9_remote_enable,
  input wire logic pin9_remote_level,
  input wire logic pin9_func_out,
  input wire logic [alias_mailbox_pkg::NUM_PINS-1:0] pins_selected,
  input wire logic [alias_mailbox_pkg::NUM_PINS-1:0] pins_func_out,
  output logic pin9_out,
  output logic pin9_oe,
  output logic [alias_mailbox_pkg::NUM_PINS-1:0] pins_out,
  output logic [alias_mailbox_pkg::NUM_PINS-1:0] pins_oe
);
  logic [7:0] remote_target_alias_seven;
  logic [7:0] scratch_mailbox_a;
  logic [7:0] scratch_mailbox_b;
  logic [7:0] pin9_and_global_pin_config;
  logic [7:0] next_alias, next_mbox_a, next_mbox_b, next_pincfg, next_rdata;
  alias_mailbox_pkg::txn_s next_fwd;
  alias_mailbox_pkg::pin_mode_e glb_mode, p9_mode;
  logic pin9_direction, pin9_select, pin9_drive_level, glb_level;

  function automatic alias_mailbox_pkg::pin_mode_e decode_mode(input logic dir, input logic en);
    case ({dir, en})
      2'b00: decode_mode = alias_mailbox_pkg::PIN_FUNC_OUT;
      2'b10: decode_mode = alias_mailbox_pkg::PIN_HIZ;
      2'b01: decode_mode = alias_mailbox_pkg::PIN_GP_OUT;
      default: decode_mode = alias_mailbox_pkg::PIN_GP_IN;
    endcase
  endfunction : decode_mode

  always_comb begin
    next_alias = remote_target_alias_seven;
    next_mbox_a = scratch_mailbox_a;
    next_mbox_b = scratch_mailbox_b;
    next_pincfg = pin9_and_global_pin_config;
    if (reg_req.wr) begin
      case (reg_req.addr)
        alias_mailbox_pkg::ADDR_ALIAS: next_alias = {reg_req.wdata[7:1], 1'b0};
        alias_mailbox_pkg::ADDR_MBOX_A: next_mbox_a = reg_req.wdata;
        alias_mailbox_pkg::ADDR_MBOX_B: next_mbox_b = reg_req.wdata;
        alias_mailbox_pkg::ADDR_PINCFG: next_pincfg = reg_req.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      remote_target_alias_seven <= alias_mailbox_pkg::RST_ALIAS;
      scratch_mailbox_a <= alias_mailbox_pkg::RST_MBOX_A;
      scratch_mailbox_b <= alias_mailbox_pkg::RST_MBOX_B;
      pin9_and_global_pin_config <= alias_mailbox_pkg::RST_PINCFG;
    end else if (clk_en) begin
      remote_target_alias_seven <= next_alias;
      scratch_mailbox_a <= next_mbox_a;
      scratch_mailbox_b <= next_mbox_b;
      pin9_and_global_pin_config <= next_pincfg;
    end
  end

  // Read data is registered: it lands one edge after the address is presented
  always_comb begin
    case (reg_req.addr)
      alias_mailbox_pkg::ADDR_ALIAS: next_rdata = remote_target_alias_seven;
      alias_mailbox_pkg::ADDR_MBOX_A: next_rdata = scratch_mailbox_a;
      alias_mailbox_pkg::ADDR_MBOX_B: next_rdata = scratch_mailbox_b;
      alias_mailbox_pkg::ADDR_PINCFG: next_rdata = pin9_and_global_pin_config;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= next_rdata;
    end
  end

  // Alias match and address remap, registered
  always_comb begin
    next_fwd = '0;
    if (local_txn.valid && remote_target_alias_seven[7:1] != 7'h00
        && local_txn.addr == remote_target_alias_seven[7:1]) begin
      next_fwd.valid = 1'b1;
      next_fwd.addr = remote_target_id;
      next_fwd.rnw = local_txn.rnw;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fwd_txn <= '0;
    end else if (clk_en) begin
      fwd_txn <= next_fwd;
    end
  end

  assign glb_level = pin9_and_global_pin_config[alias_mailbox_pkg::GLB_LEVEL_BIT];
  assign pin9_drive_level = pin9_and_global_pin_config[alias_mailbox_pkg::P9_LEVEL_BIT];
  assign pin9_direction = pin9_and_global_pin_config[alias_mailbox_pkg::P9_DIR_BIT];
  assign pin9_select = pin9_and_global_pin_config[alias_mailbox_pkg::P9_SEL_BIT];
  assign glb_mode = decode_mode(pin9_and_global_pin_config[alias_mailbox_pkg::GLB_DIR_BIT],
                                pin9_and_global_pin_config[alias_mailbox_pkg::GLB_EN_BIT]);
  assign p9_mode = decode_mode(pin9_direction, pin9_select);

  // Pin 9: its own settings, never the global force, steer it
  always_comb begin
    pin9_out = 1'b0;
    pin9_oe = 1'b0;
    case (p9_mode)
      alias_mailbox_pkg::PIN_FUNC_OUT: begin
        pin9_out = pin9_func_out;
        pin9_oe = 1'b1;
      end
      alias_mailbox_pkg::PIN_GP_OUT: begin
        pin9_oe = 1'b1;
        pin9_out = pin9_remote_enable ? pin9_remote_level : pin9_drive_level;
      end
      default: begin
        pin9_oe = 1'b0;
      end
    endcase
  end

  // Other pins follow the global force only when not individually selected
  always_comb begin
    pins_out = pins_func_out;
    pins_oe = '1;
    for (int i = 0; i < alias_mailbox_pkg::NUM_PINS; i++) begin
      if (!pins_selected[i]) begin
        case (glb_mode)
          alias_mailbox_pkg::PIN_GP_OUT: pins_out[i] = glb_level;
          alias_mailbox_pkg::PIN_HIZ, alias_mailbox_pkg::PIN_GP_IN: pins_oe[i] = 1'b0;
          default: ;
        endcase
      end
    end
  end

  // Checks read raw config bits where they can, so a broken decoder still trips them
  a_alias_bit0_zero: assert property (@(posedge mclk) disable iff (rst)
    remote_target_alias_seven[0] == 1'b0) else $error("alias bit 0 not zero");
  a_alias_store: assert property (@(posedge mclk) disable iff (rst)
    clk_en && reg_req.wr && reg_req.addr == alias_mailbox_pkg::ADDR_ALIAS
    |=> remote_target_alias_seven[7:1] == $past(reg_req.wdata[7:1]))
    else $error("alias address not stored");
  a_fwd_zero_off: assert property (@(posedge mclk) disable iff (rst)
    $past(clk_en) && $past(remote_target_alias_seven[7:1]) == 7'h00 |-> !fwd_txn.valid)
    else $error("forward with zero alias");
  a_fwd_on_match: assert property (@(posedge mclk) disable iff (rst)
    clk_en && local_txn.valid && remote_target_alias_seven[7:1] != 7'h00
    && local_txn.addr == remote_target_alias_seven[7:1] ##1 1'b1 |-> fwd_txn.valid)
    else $error("match not forwarded");
  a_fwd_remap: assert property (@(posedge mclk) disable iff (rst)
    clk_en && next_fwd.valid |=> fwd_txn.addr == $past(remote_target_id))
    else $error("address not remapped");
  a_mbox_write: assert property (@(posedge mclk) disable iff (rst)
    clk_en && reg_req.wr && reg_req.addr == alias_mailbox_pkg::ADDR_MBOX_A
    |=> scratch_mailbox_a == $past(reg_req.wdata)) else $error("mailbox a lost write");
  a_mbox_b_hold: assert property (@(posedge mclk) disable iff (rst)
    !(reg_req.wr && reg_req.addr == alias_mailbox_pkg::ADDR_MBOX_B)
    |=> $stable(scratch_mailbox_b)) else $error("mailbox b changed");
  a_freeze_mbox: assert property (@(posedge mclk) disable iff (rst)
    !clk_en |=> $stable(scratch_mailbox_a) && $stable(scratch_mailbox_b))
    else $error("mailbox changed while frozen");
  a_glb_force_out: assert property (@(posedge mclk) disable iff (rst)
    glb_mode == alias_mailbox_pkg::PIN_GP_OUT |-> (pins_oe | pins_selected) == '1
    && ((pins_out ^ {alias_mailbox_pkg::NUM_PINS{glb_level}}) & ~pins_selected) == '0)
    else $error("global level not driven");
  a_glb_off: assert property (@(posedge mclk) disable iff (rst)
    pin9_and_global_pin_config[alias_mailbox_pkg::GLB_DIR_BIT]
    |-> (pins_oe & ~pins_selected) == '0) else $error("global tri-state or input driven");
  a_sel_priority: assert property (@(posedge mclk) disable iff (rst)
    (pins_oe & pins_selected) == pins_selected
    && ((pins_out ^ pins_func_out) & pins_selected) == '0)
    else $error("selected pin overridden");
  a_p9_level: assert property (@(posedge mclk) disable iff (rst)
    !pin9_direction && pin9_select && !pin9_remote_enable
    |-> pin9_oe && pin9_out == pin9_drive_level) else $error("pin 9 level wrong");
  a_p9_func: assert property (@(posedge mclk) disable iff (rst)
    !pin9_direction && !pin9_select |-> pin9_oe && pin9_out == pin9_func_out)
    else $error("pin 9 functional output wrong");
  a_p9_hiz: assert property (@(posedge mclk) disable iff (rst)
    pin9_direction |-> !pin9_oe) else $error("pin 9 driven while off or input");
  a_reset_vals: assert property (@(posedge mclk)
    $fell(rst) |-> scratch_mailbox_b == 8'h01 && scratch_mailbox_a == 8'h00
    && remote_target_alias_seven == 8'h00 && pin9_and_global_pin_config == 8'h00)
    else $error("bad reset values");

  // Scenarios the bench is expected to reach
  c_forward: cover property (@(posedge mclk) disable iff (rst) fwd_txn.valid);
  c_glb_force: cover property (@(posedge mclk) disable iff (rst)
    glb_mode == alias_mailbox_pkg::PIN_GP_OUT);
  c_p9_gp_out: cover property (@(posedge mclk) disable iff (rst)
    p9_mode == alias_mailbox_pkg::PIN_GP_OUT);
  c_frozen_write: cover property (@(posedge mclk) disable iff (rst)
    !clk_en && reg_req.wr);
  c_remote_pin: cover property (@(posedge mclk) disable iff (rst)
    p9_mode == alias_mailbox_pkg::PIN_GP_OUT && pin9_remote_enable);
endmodule : alias_mailbox_pin_config_regs
`default_nettype wire

// ### remote_far_end.sv
`timescale 1ns/10ps
`default_nettype none
module remote_far_end (
  input wire logic mclk,
  input wire logic rst,
  input wire alias_mailbox_pkg::txn_s fwd_txn,
  input wire logic [6:0] id_cfg,
  input wire logic [1:0] pin_ctl,
  output logic [6:0] remote_target_id,
  output logic pin9_remote_enable,
  output logic pin9_remote_level,
  output int fwd_seen,
  output logic [7:0] last_fwd
);
  assign remote_target_id = id_cfg;
  assign pin9_remote_enable = pin_ctl[1];
  assign pin9_remote_level = pin_ctl[0];
  // Far target logs each address that reaches it across the link
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fwd_seen <= 0;
      last_fwd <= 8'h00;
    end else if (fwd_txn.valid) begin
      fwd_seen <= fwd_seen + 1;
      last_fwd <= {fwd_txn.addr, fwd_txn.rnw};
    end
  end
endmodule : remote_far_end
`default_nettype wire

// ### alias_mailbox_pin_config_regs_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module alias_mailbox_pin_config_regs_tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  alias_mailbox_pkg::reg_req_s req = '0;
  alias_mailbox_pkg::txn_s txn = '0;
  alias_mailbox_pkg::txn_s fwd;
  logic [7:0] rdata, last_fwd;
  logic [6:0] tid;
  logic ren, rlvl, p9_out, p9_oe;
  logic [1:0] pin_ctl = 2'h0;
  logic p9_func = 1'b0;
  logic [3:0] sel = 4'h1;
  logic [3:0] func = 4'ha;
  logic [3:0] p_out, p_oe;
  int fwd_seen, fail_count = 0, cmp_count = 0;
  always #2 mclk = ~mclk;
  alias_mailbox_pin_config_regs i_alias_mailbox_pin_config_regs (.mclk(mclk), .rst(rst),
    .clk_en(clk_en), .reg_req(req), .reg_rdata(rdata), .local_txn(txn), .remote_target_id(tid),
    .fwd_txn(fwd), .pin9_remote_enable(ren), .pin9_remote_level(rlvl), .pin9_func_out(p9_func),
    .pins_selected(sel), .pins_func_out(func), .pin9_out(p9_out), .pin9_oe(p9_oe),
    .pins_out(p_out), .pins_oe(p_oe));
  remote_far_end i_remote_far_end (.mclk(mclk), .rst(rst), .fwd_txn(fwd), .id_cfg(7'h5c),
    .pin_ctl(pin_ctl), .remote_target_id(tid), .pin9_remote_enable(ren),
    .pin9_remote_level(rlvl), .fwd_seen(fwd_seen), .last_fwd(last_fwd));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{1'b1, a, d};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    req.addr <= a;
    // Read data is registered, so it is looked at one edge later
    @(posedge mclk);
    #1 chk(rdata, exp);
  endtask : rd
  // Sends one local transaction and waits out the one-cycle forward latency
  task automatic send(input logic [6:0] a);
    @(posedge mclk);
    txn <= '{1'b1, a, 1'b1};
    @(posedge mclk);
    txn.valid <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask : send
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  initial begin
    #4000;
    fail_count++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    rd(8'h17, 8'h00);
    rd(8'h18, 8'h00);
    rd(8'h19, 8'h01);
    rd(8'h1a, 8'h00);
    chk({7'h0, p9_oe}, 8'h01);
    wr(8'h18, 8'h55);
    wr(8'h19, 8'haa);
    wr(8'h1b, 8'hff);
    wr(8'h17, 8'hff);
    rd(8'h18, 8'h55);
    rd(8'h19, 8'haa);
    rd(8'h1b, 8'h00);
    rd(8'h17, 8'hfe);
    wr(8'h1a, 8'h44);
    rd(8'h1a, 8'h44);
    @(posedge mclk);
    clk_en <= 1'b0;
    wr(8'h18, 8'h33);
    clk_en <= 1'b1;
    rd(8'h18, 8'h55);
    wr(8'h17, 8'h54);
    send(7'h2a);
    chk(8'(fwd_seen), 8'h01);
    chk(last_fwd, 8'hb9);
    send(7'h2b);
    chk(8'(fwd_seen), 8'h01);
    wr(8'h17, 8'h00);
    send(7'h00);
    chk(8'(fwd_seen), 8'h01);
    for (int v = 0; v < 4; v++) begin
      wr(8'h1a, 8'h08 | 8'(v));
      @(posedge mclk);
      #1 chk({7'h0, p9_oe}, 8'(v < 2));
      if (v < 2) chk({7'h0, p9_out}, 8'(v & 1));
    end
    wr(8'h1a, 8'h09);
    pin_ctl <= 2'b10;
    @(posedge mclk);
    #1 chk({6'h0, p9_oe, p9_out}, 8'h02);
    for (int g = 0; g < 4; g++) begin
      wr(8'h1a, 8'h80 | 8'(g << 4));
      @(posedge mclk);
      #1 chk({4'h0, p_oe}, g < 2 ? 8'h0f : 8'h01);
      chk({4'h0, p_out & p_oe}, g == 0 ? 8'h0a : g == 1 ? 8'h0e : 8'h00);
      chk({7'h0, p9_oe}, 8'h01);
    end
    wr(8'h17, 8'h54);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(8'h17, 8'h00);
    rd(8'h18, 8'h00);
    rd(8'h19, 8'h01);
    rd(8'h1a, 8'h00);
    stop_test();
  end
endmodule : alias_mailbox_pin_config_regs_tb_top
`default_nettype wire
